// ==== rtl/pafo_defs.svh ====
// Constants for the port alternate function override block
`ifndef PAFO_DEFS_SVH
`define PAFO_DEFS_SVH
// ==========================================
// Register offsets
`define PAFO_OFS_PB_DATA 3'h0
`define PAFO_OFS_PB_DIR 3'h1
`define PAFO_OFS_PB_PIN 3'h2
`define PAFO_OFS_PC_DATA 3'h3
`define PAFO_OFS_PC_PIN 3'h4
// ==========================================
// Reset values
`define PAFO_RST_BYTE 8'h00
`define PAFO_RST_PC 7'h00
// ==========================================
// Lane positions
`define PAFO_LANE_B 0
`define PAFO_LANE_C 8
`define PAFO_LANE_D 16
`define PAFO_PC_RESET_BIT 6
`define PAFO_PD_RX 16
`define PAFO_PD_TX 17
`define PAFO_PD_IRQ0 18
`define PAFO_PD_IRQ1 19
`define PAFO_PD_XCK 20
`define PAFO_PD_T1 21
`define PAFO_PC_SDA 12
`define PAFO_PC_SCL 13
`define PAFO_PC_RST 14
// ==========================================
// Timing
`define PAFO_CLK_MHZ 100
`define PAFO_SPIKE_NS 50
`define PAFO_SPIKE_CYC ((`PAFO_SPIKE_NS * `PAFO_CLK_MHZ + 999) / 1000)
`endif

// ==== rtl/pafo_pkg.sv ====
// Types shared by the port override modules
`default_nettype none
package pafo_pkg;
  typedef logic [7:0] pafo_byte_t;
  typedef logic [23:0] pafo_lane_t;
  typedef logic [2:0] pafo_addr_t;
endpackage : pafo_pkg
`default_nettype wire

// ==== rtl/pafo_lvl_if.sv ====
// Raw and synchronised pin levels between top and synchroniser
`default_nettype none
interface pafo_lvl_if;
  import pafo_pkg::*;
  pafo_lane_t raw;
  pafo_lane_t synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface : pafo_lvl_if
`default_nettype wire

// ==== rtl/pafo_pin_sync.sv ====
// Two-flop synchroniser for all pad input lanes
`default_nettype none
module pafo_pin_sync
  import pafo_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  pafo_lvl_if.dst lvl
);
  pafo_lane_t stage1_r;
  pafo_lane_t stage2_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= lvl.raw;
      stage2_r <= stage1_r;
    end
  end

  assign lvl.synced = stage2_r;
endmodule : pafo_pin_sync
`default_nettype wire

// ==== rtl/pafo_spike_filter.sv ====
// Spike filter for the two-wire clock and data inputs
`default_nettype none
`include "pafo_defs.svh"
module pafo_spike_filter
  import pafo_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] rawLevel,
  output logic [1:0] cleanLevel
);
  localparam logic [2:0] LastCnt = 3'(`PAFO_SPIKE_CYC - 1);

  for (genvar i = 0; i < 2; i++) begin : g_lane
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic out_r;
    logic out_nxt;

    // Output follows only after the input held a new level long enough
    always_comb begin
      cnt_nxt = 3'h0;
      out_nxt = out_r;
      if (rawLevel[i] != out_r) begin
        if (cnt_r == LastCnt) begin
          out_nxt = rawLevel[i];
        end else begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        cnt_r <= 3'h0;
        out_r <= 1'b0;
      end else begin
        cnt_r <= cnt_nxt;
        out_r <= out_nxt;
      end
    end

    assign cleanLevel[i] = out_r;
  end
endmodule : pafo_spike_filter
`default_nettype wire

// ==== rtl/pafo_top.sv ====
// Port pin override logic with port B and port C data registers
`default_nettype none
`include "pafo_defs.svh"
// Operation
// - Reset pin pull-up, direction, input overrides follow fuse; values zero.
// - Two-wire pins: gated pull-up, direction from drive, output forced 0.
// - Two-wire enable turns on slew limiting of both its pins.
// - Spike filters sit between two-wire pins and interface logic.
// - Analog port low four pins have no overrides at all.
// - Enabled transmitter makes transmit pin an output regardless of direction.
// - Transmit pin: pull-up 0, output, serial data; receive pin input.
// - Forced receive pin keeps pull-up from its data bit, gated.
// - USART clock pin value follows clock output in synchronous mode.
// - Enabled external interrupt forces its input buffer on.
// - Port B direction is eight bits, read/write, reset to inputs.
// - Port B pin levels register is read-only sampled pin levels.
// - Port C data bit 7 reads zero; bits 6..0 writable, reset 0.
// - Reset pin mode reads its data and pin bits as zero.
module pafo_top
  import pafo_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  input wire logic [7:0] portBPadIn,
  output logic [7:0] portBPadOut,
  output logic [7:0] portBPadOe,
  output logic [7:0] portBPullUp,
  input wire logic [6:0] portCPadIn,
  output logic [6:0] portCPadOut,
  output logic [6:0] portCPadOe,
  output logic [6:0] portCPullUp,
  input wire logic [6:0] portCDirection,
  input wire logic [7:0] portDPadIn,
  output logic [7:0] portDPadOut,
  output logic [7:0] portDPadOe,
  output logic [7:0] portDPullUp,
  input wire logic [7:0] portDData,
  input wire logic [7:0] portDDirection,
  input wire logic globalPullupDisable,
  input wire logic resetPinDisableFuse,
  output logic resetPinLevel,
  input wire logic twoWireEnable,
  input wire logic twiSclDrive,
  input wire logic twiSdaDrive,
  output logic twiSclIn,
  output logic twiSdaIn,
  output logic [1:0] twiSlewLimit,
  input wire logic transmitterEnable,
  input wire logic txSerialData,
  input wire logic receiverEnable,
  output logic rxSerialData,
  input wire logic usartSyncModeSelect,
  input wire logic usartClockOut,
  output logic usartClockIn,
  output logic counter0ClockIn,
  output logic counter1ClockIn,
  input wire logic [1:0] extIrqEnable,
  output logic [1:0] extIrqPinLevel
);
  // ==========================================
  // Registers
  pafo_byte_t portBData_r;
  pafo_byte_t portBData_nxt;
  pafo_byte_t portBDir_r;
  pafo_byte_t portBDir_nxt;
  logic [6:0] portCData_r;
  logic [6:0] portCData_nxt;
  pafo_byte_t rdData_r;
  pafo_byte_t rdData_nxt;
  logic resetPinMode;
  logic [1:0] twiRaw;

  pafo_lvl_if lvl ();
  pafo_lane_t syncd;
  pafo_lane_t laneData;
  pafo_lane_t laneDir;
  pafo_lane_t pullup_override_enable, pullup_override_value, direction_override_enable, direction_override_value, output_value_override_enable, output_value_override_value, input_buffer_override_enable, input_buffer_override_value;
  pafo_lane_t dirEff, outEff, pullEff, dieEff, digIn;

  assign resetPinMode = ~resetPinDisableFuse;

  always_comb begin
    portBData_nxt = portBData_r;
    portBDir_nxt = portBDir_r;
    portCData_nxt = portCData_r;
    if (regWrStb) begin
      unique case (regAddr)
        `PAFO_OFS_PB_DATA: portBData_nxt = regWrData;
        `PAFO_OFS_PB_DIR: portBDir_nxt = regWrData;
        `PAFO_OFS_PC_DATA: portCData_nxt = regWrData[6:0];
        default: portBData_nxt = portBData_r;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_comb begin
    rdData_nxt = 8'h00;
    if (regRdStb) begin
      unique case (regAddr)
        `PAFO_OFS_PB_DATA: rdData_nxt = portBData_r;
        `PAFO_OFS_PB_DIR: rdData_nxt = portBDir_r;
        `PAFO_OFS_PB_PIN: rdData_nxt = syncd[7:0];
        `PAFO_OFS_PC_DATA: begin
          rdData_nxt = {1'b0, portCData_r};
          if (resetPinMode) begin
            rdData_nxt[`PAFO_PC_RESET_BIT] = 1'b0;
          end
        end
        `PAFO_OFS_PC_PIN: begin
          rdData_nxt = {1'b0, syncd[14:8]};
          if (resetPinMode) begin
            rdData_nxt[`PAFO_PC_RESET_BIT] = 1'b0;
          end
        end
        default: rdData_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      portBData_r <= `PAFO_RST_BYTE;
      portBDir_r <= `PAFO_RST_BYTE;
      portCData_r <= `PAFO_RST_PC;
      rdData_r <= `PAFO_RST_BYTE;
    end else begin
      portBData_r <= portBData_nxt;
      portBDir_r <= portBDir_nxt;
      portCData_r <= portCData_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign regRdData = rdData_r;

  // ==========================================
  // Pin input synchronisation
  assign lvl.raw = {portDPadIn, 1'b0, portCPadIn, portBPadIn};
  assign syncd = lvl.synced;

  pafo_pin_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .lvl(lvl)
  );

  // ==========================================
  // Override sources
  always_comb begin
    pullup_override_enable = '0;
    pullup_override_value = '0;
    direction_override_enable = '0;
    direction_override_value = '0;
    output_value_override_enable = '0;
    output_value_override_value = '0;
    input_buffer_override_enable = '0;
    input_buffer_override_value = '0;
    // Reset-capable pin
    pullup_override_enable[`PAFO_PC_RST] = resetPinDisableFuse;
    direction_override_enable[`PAFO_PC_RST] = resetPinDisableFuse;
    input_buffer_override_enable[`PAFO_PC_RST] = resetPinDisableFuse;
    // Two-wire pins, open drain
    pullup_override_enable[`PAFO_PC_SCL] = twoWireEnable;
    pullup_override_enable[`PAFO_PC_SDA] = twoWireEnable;
    pullup_override_value[`PAFO_PC_SCL] = portCData_r[5] & ~globalPullupDisable;
    pullup_override_value[`PAFO_PC_SDA] = portCData_r[4] & ~globalPullupDisable;
    direction_override_enable[`PAFO_PC_SCL] = twoWireEnable;
    direction_override_enable[`PAFO_PC_SDA] = twoWireEnable;
    direction_override_value[`PAFO_PC_SCL] = twiSclDrive;
    direction_override_value[`PAFO_PC_SDA] = twiSdaDrive;
    output_value_override_enable[`PAFO_PC_SCL] = twoWireEnable;
    output_value_override_enable[`PAFO_PC_SDA] = twoWireEnable;
    // Analog lanes 8..11 stay without overrides
    // Receive pin
    pullup_override_enable[`PAFO_PD_RX] = receiverEnable;
    pullup_override_value[`PAFO_PD_RX] = portDData[0] & ~globalPullupDisable;
    direction_override_enable[`PAFO_PD_RX] = receiverEnable;
    // Transmit pin
    pullup_override_enable[`PAFO_PD_TX] = transmitterEnable;
    direction_override_enable[`PAFO_PD_TX] = transmitterEnable;
    direction_override_value[`PAFO_PD_TX] = 1'b1;
    output_value_override_enable[`PAFO_PD_TX] = transmitterEnable;
    output_value_override_value[`PAFO_PD_TX] = txSerialData;
    // External interrupt pins
    input_buffer_override_enable[`PAFO_PD_IRQ0] = extIrqEnable[0];
    input_buffer_override_enable[`PAFO_PD_IRQ1] = extIrqEnable[1];
    input_buffer_override_value[`PAFO_PD_IRQ0] = 1'b1;
    input_buffer_override_value[`PAFO_PD_IRQ1] = 1'b1;
    // USART clock pin
    output_value_override_enable[`PAFO_PD_XCK] = usartSyncModeSelect;
    output_value_override_value[`PAFO_PD_XCK] = usartClockOut;
  end

  // ==========================================
  // Per-lane override muxes
  assign laneData = {portDData, 1'b0, portCData_r, portBData_r};
  assign laneDir = {portDDirection, 1'b0, portCDirection, portBDir_r};

  for (genvar i = 0; i < 24; i++) begin : g_lane
    assign dirEff[i] = direction_override_enable[i] ? direction_override_value[i] : laneDir[i];
    assign outEff[i] = output_value_override_enable[i] ? output_value_override_value[i] : laneData[i];
    assign pullEff[i] = pullup_override_enable[i] ? pullup_override_value[i]
        : (laneData[i] & ~laneDir[i] & ~globalPullupDisable);
    assign dieEff[i] = input_buffer_override_enable[i] ? input_buffer_override_value[i] : 1'b1;
    assign digIn[i] = syncd[i] & dieEff[i];
  end

  assign portBPadOut = outEff[7:0];
  assign portBPadOe = dirEff[7:0];
  assign portBPullUp = pullEff[7:0];
  assign portCPadOut = outEff[14:8];
  assign portCPadOe = dirEff[14:8];
  assign portCPullUp = pullEff[14:8];
  assign portDPadOut = outEff[23:16];
  assign portDPadOe = dirEff[23:16];
  assign portDPullUp = pullEff[23:16];

  // ==========================================
  // Peripheral inputs
  assign resetPinLevel = syncd[`PAFO_PC_RST];
  assign rxSerialData = digIn[`PAFO_PD_RX];
  assign usartClockIn = digIn[`PAFO_PD_XCK];
  assign counter0ClockIn = digIn[`PAFO_PD_XCK];
  assign counter1ClockIn = digIn[`PAFO_PD_T1];
  assign extIrqPinLevel = {digIn[`PAFO_PD_IRQ1], digIn[`PAFO_PD_IRQ0]};
  assign twiSlewLimit = {2{twoWireEnable}};
  assign twiRaw = {syncd[`PAFO_PC_SCL], syncd[`PAFO_PC_SDA]};

  pafo_spike_filter u_filt (
    .clk_sys(clk_sys),
    .rst(rst),
    .rawLevel(twiRaw),
    .cleanLevel({twiSclIn, twiSdaIn})
  );

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_reset_pin;
    resetPinDisableFuse |-> !portCPadOe[6] && !portCPullUp[6];
  endproperty
  a_reset_pin: assert property (p_reset_pin)
    else $error("reset pin override wrong");

  property p_twi_od;
    twoWireEnable |-> portCPadOut[5:4] == 2'b00
      && portCPadOe[5] == twiSclDrive && portCPadOe[4] == twiSdaDrive;
  endproperty
  a_twi_od: assert property (p_twi_od)
    else $error("two-wire pin not open drain");

  property p_slew;
    twiSlewLimit == (twoWireEnable ? 2'b11 : 2'b00);
  endproperty
  a_slew: assert property (p_slew)
    else $error("slew limit mismatch");

  property p_spike;
    $changed(twiSclIn) |-> $past(twiRaw[1], 1) == twiSclIn
      && $past(twiRaw[1], 5) == twiSclIn;
  endproperty
  a_spike: assert property (p_spike)
    else $error("clock passed filter too early");

  property p_analog;
    portCPadOe[3:0] == portCDirection[3:0]
      && portCPadOut[3:0] == portCData_r[3:0];
  endproperty
  a_analog: assert property (p_analog)
    else $error("analog pin overridden");

  property p_tx;
    transmitterEnable |-> portDPadOe[1] && !portDPullUp[1]
      && portDPadOut[1] == txSerialData;
  endproperty
  a_tx: assert property (p_tx)
    else $error("transmit pin override wrong");

  property p_rx;
    receiverEnable |-> !portDPadOe[0]
      && portDPullUp[0] == (portDData[0] & ~globalPullupDisable);
  endproperty
  a_rx: assert property (p_rx)
    else $error("receive pin override wrong");

  property p_xck;
    usartSyncModeSelect |-> portDPadOut[4] == usartClockOut
      && usartClockIn == counter0ClockIn;
  endproperty
  a_xck: assert property (p_xck)
    else $error("usart clock pin wrong");

  property p_irq;
    extIrqEnable[0] |-> extIrqPinLevel[0] == syncd[`PAFO_PD_IRQ0];
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt input buffer off");

  property p_dir_wr;
    regWrStb && regAddr == `PAFO_OFS_PB_DIR
      |=> portBPadOe == $past(regWrData);
  endproperty
  a_dir_wr: assert property (p_dir_wr)
    else $error("direction write lost");

  property p_port_b_pin_levels_ro;
    regWrStb && regAddr == `PAFO_OFS_PB_PIN
      |=> $stable(portBPadOut) && $stable(portBPadOe);
  endproperty
  a_port_b_pin_levels_ro: assert property (p_port_b_pin_levels_ro)
    else $error("pin levels register written");

  property p_pc7;
    regRdStb && regAddr == `PAFO_OFS_PC_DATA |=> !regRdData[7];
  endproperty
  a_pc7: assert property (p_pc7)
    else $error("port C bit 7 not zero");

  property p_rst_read;
    regRdStb && resetPinMode && (regAddr == `PAFO_OFS_PC_DATA
      || regAddr == `PAFO_OFS_PC_PIN) |=> !regRdData[6];
  endproperty
  a_rst_read: assert property (p_rst_read)
    else $error("reset pin bit reads one");

  property p_pin_sync;
    regRdStb && regAddr == `PAFO_OFS_PB_PIN
      |=> regRdData == $past(portBPadIn, 3);
  endproperty
  a_pin_sync: assert property (p_pin_sync)
    else $error("pin read latency wrong");

  c_tx: cover property (transmitterEnable && portDPadOe[1]);
  c_twi: cover property (twoWireEnable && twiSclDrive);
  c_pin: cover property (regRdStb && regAddr == `PAFO_OFS_PB_PIN);
  c_irq: cover property (extIrqEnable[1] && extIrqPinLevel[1]);
endmodule : pafo_top
`default_nettype wire

// ==== test/pafo_pad_model.sv ====
// Board side of the port pads: external drivers, pull-ups, floating lines
`default_nettype none
module pafo_pad_model #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic [WIDTH-1:0] dutOut,
  input wire logic [WIDTH-1:0] dutOe,
  input wire logic [WIDTH-1:0] dutPullUp,
  input wire logic [WIDTH-1:0] extOe,
  input wire logic [WIDTH-1:0] extVal,
  output logic [WIDTH-1:0] padLevel
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [WIDTH-1:0] floatPat = '0;
  // ==========================================
  // Undriven line without pull-up changes every cycle
  always @(posedge clk_sys) begin
    floatPat <= ~floatPat;
  end
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (dutOe[i]) padLevel[i] = dutOut[i];
      else if (extOe[i]) padLevel[i] = extVal[i];
      else if (dutPullUp[i]) padLevel[i] = 1'b1;
      else padLevel[i] = floatPat[i];
    end
  end
endmodule : pafo_pad_model
`default_nettype wire

// ==== test/tb_top.sv ====
// Register and pin override tests for the port override block
`default_nettype none
`include "pafo_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pafo_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  pafo_addr_t regAddr = '0;
  pafo_byte_t regWrData = '0;
  logic regWrStb = 1'b0, regRdStb = 1'b0;
  pafo_byte_t regRdData;
  logic [7:0] bIn, bOut, bOe, bPu, dIn, dOut, dOe, dPu;
  logic [6:0] cIn, cOut, cOe, cPu;
  logic rstLvl, sclIn, sdaIn, rxData, xckIn, t0In, t1In;
  logic [1:0] slew, irqLvl;
  logic [7:0] bExtOe = '0, bExtVal = '0, dExtOe = '0, dExtVal = '0;
  logic [7:0] dData = '0, dDir = '0;
  logic [6:0] cDir = '0, cExtOe = '0, cExtVal = '0;
  logic global_pullup_disable = 1'b0, fuse = 1'b0, two_wire_enable = 1'b0, sclDrv = 1'b0;
  logic sdaDrv = 1'b0, transmitter_enable = 1'b0, txData = 1'b0, receiver_enable = 1'b0;
  logic syncSel = 1'b0, xckOut = 1'b0;
  logic [1:0] irqEn = '0;
  int err_count = 0, comparisons = 0;

  always #5 clk_sys = ~clk_sys;

  pafo_top dut_u (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .portBPadIn(bIn), .portBPadOut(bOut),
    .portBPadOe(bOe), .portBPullUp(bPu), .portCPadIn(cIn),
    .portCPadOut(cOut), .portCPadOe(cOe), .portCPullUp(cPu),
    .portCDirection(cDir), .portDPadIn(dIn), .portDPadOut(dOut),
    .portDPadOe(dOe), .portDPullUp(dPu), .portDData(dData),
    .portDDirection(dDir), .globalPullupDisable(global_pullup_disable),
    .resetPinDisableFuse(fuse), .resetPinLevel(rstLvl),
    .twoWireEnable(two_wire_enable), .twiSclDrive(sclDrv), .twiSdaDrive(sdaDrv),
    .twiSclIn(sclIn), .twiSdaIn(sdaIn), .twiSlewLimit(slew),
    .transmitterEnable(transmitter_enable), .txSerialData(txData),
    .receiverEnable(receiver_enable), .rxSerialData(rxData),
    .usartSyncModeSelect(syncSel), .usartClockOut(xckOut),
    .usartClockIn(xckIn), .counter0ClockIn(t0In),
    .counter1ClockIn(t1In), .extIrqEnable(irqEn), .extIrqPinLevel(irqLvl));
  pafo_pad_model #(.WIDTH(8)) padB_u (.clk_sys(clk_sys), .dutOut(bOut),
    .dutOe(bOe), .dutPullUp(bPu), .extOe(bExtOe), .extVal(bExtVal),
    .padLevel(bIn));
  pafo_pad_model #(.WIDTH(7)) padC_u (.clk_sys(clk_sys), .dutOut(cOut),
    .dutOe(cOe), .dutPullUp(cPu), .extOe(cExtOe), .extVal(cExtVal),
    .padLevel(cIn));
  pafo_pad_model #(.WIDTH(8)) padD_u (.clk_sys(clk_sys), .dutOut(dOut),
    .dutOe(dOe), .dutPullUp(dPu), .extOe(dExtOe), .extVal(dExtVal),
    .padLevel(dIn));

  // ==========================================
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wr(input pafo_addr_t a, input pafo_byte_t d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk_sys);
    regWrStb <= 1'b0;
    #1;
  endtask : wr
  task automatic rdChk(input pafo_addr_t a, input pafo_byte_t exp,
                       input pafo_byte_t mask);
    @(posedge clk_sys);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    #1;
    check(regRdData & mask, exp);
  endtask : rdChk
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  initial begin
    #50us;
    err_count++;
    summarize();
  end

  // ==========================================
  // Test sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rdChk(`PAFO_OFS_PB_DIR, 8'h00, 8'hff);
    rdChk(`PAFO_OFS_PC_DATA, 8'h00, 8'hff);
    rdChk(3'h7, 8'h00, 8'hff);
    $display("Test reset values done");
    wr(`PAFO_OFS_PB_DIR, 8'hff);
    wr(`PAFO_OFS_PB_DATA, 8'ha5);
    check(bOe, 8'hff);
    check(bOut, 8'ha5);
    rdChk(`PAFO_OFS_PB_DIR, 8'hff, 8'hff);
    wr(`PAFO_OFS_PB_DIR, 8'h00);
    wr(`PAFO_OFS_PB_DATA, 8'h00);
    bExtOe <= 8'hff;
    bExtVal <= 8'h3c;
    wr(`PAFO_OFS_PB_PIN, 8'h55);
    tick(4);
    rdChk(`PAFO_OFS_PB_PIN, 8'h3c, 8'hff);
    @(posedge clk_sys);
    bExtVal <= 8'hc3;
    rdChk(`PAFO_OFS_PB_PIN, 8'h3c, 8'hff);
    rdChk(`PAFO_OFS_PB_PIN, 8'hc3, 8'hff);
    $display("Test port B done");
    wr(`PAFO_OFS_PC_DATA, 8'hff);
    cExtOe[6] <= 1'b1;
    cExtVal[6] <= 1'b1;
    tick(4);
    check(8'(rstLvl), 8'h01);
    rdChk(`PAFO_OFS_PC_DATA, 8'h3f, 8'hff);
    rdChk(`PAFO_OFS_PC_PIN, 8'h00, 8'hc0);
    cExtVal[6] <= 1'b0;
    fuse <= 1'b1;
    cDir <= 7'h4f;
    tick(4);
    check(8'(rstLvl), 8'h00);
    check(8'({cOe[6], cPu[6]}), 8'h00);
    rdChk(`PAFO_OFS_PC_DATA, 8'h7f, 8'hff);
    $display("Test port C done");
    two_wire_enable <= 1'b1;
    sclDrv <= 1'b1;
    tick(1);
    check(8'(cPu[5:4]), 8'h03);
    check(8'({cOe[5:4], cOut[5:4]}), 8'h08);
    check(8'(slew), 8'h03);
    check(8'({cOe[3:0], cPu[3:0]}), 8'hf0);
    check(8'(cOut[3:0]), 8'h0f);
    global_pullup_disable <= 1'b1;
    tick(1);
    check(8'(cPu[5:4]), 8'h00);
    global_pullup_disable <= 1'b0;
    tick(12);
    check(8'({sclIn, sdaIn}), 8'h01);
    cExtOe[4] <= 1'b1;
    tick(3);
    cExtOe[4] <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      tick(1);
      check(8'(sdaIn), 8'h01);
    end
    cExtOe[4] <= 1'b1;
    tick(4);
    check(8'(sdaIn), 8'h01);
    tick(6);
    check(8'(sdaIn), 8'h00);
    cExtOe[4] <= 1'b0;
    two_wire_enable <= 1'b0;
    cDir <= 7'h00;
    tick(1);
    check(8'({slew, cOe[5], cPu[3:0]}), 8'h0f);
    $display("Test two-wire and analog pins done");
    transmitter_enable <= 1'b1;
    txData <= 1'b1;
    receiver_enable <= 1'b1;
    dDir <= 8'h01;
    dData <= 8'h03;
    tick(1);
    check(8'({dOe[1:0], dOut[1], dPu[1:0]}), 8'h15);
    txData <= 1'b0;
    global_pullup_disable <= 1'b1;
    dExtOe[0] <= 1'b1;
    tick(4);
    check(8'({dOut[1], dPu[0], rxData}), 8'h00);
    dExtVal[0] <= 1'b1;
    global_pullup_disable <= 1'b0;
    transmitter_enable <= 1'b0;
    tick(4);
    check(8'({dOe[1], rxData}), 8'h01);
    $display("Test serial pins done");
    syncSel <= 1'b1;
    xckOut <= 1'b1;
    dDir <= 8'h10;
    dData <= 8'h00;
    tick(1);
    check(8'(dOut[4]), 8'h01);
    syncSel <= 1'b0;
    tick(1);
    check(8'(dOut[4]), 8'h00);
    dDir <= 8'h00;
    dExtOe[5:4] <= 2'b11;
    dExtVal[5:4] <= 2'b01;
    tick(4);
    check(8'({xckIn, t0In, t1In}), 8'h06);
    irqEn <= 2'b11;
    dExtOe[3:2] <= 2'b11;
    dExtVal[3:2] <= 2'b10;
    tick(4);
    check(8'(irqLvl), 8'h02);
    dExtVal[3:2] <= 2'b01;
    tick(4);
    check(8'(irqLvl), 8'h01);
    $display("Test clock and interrupt pins done");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
